// ### hdl/nand_port_pkg.sv
/*
 * shared constants and carriers for the flash target pin port.
 * assumes one system clock that oversamples every host pin.
 */
package nand_port_pkg;
    // -------------------------------------------------------------
    // widths and sizes
    // -------------------------------------------------------------
    localparam int DQ_W       = 8;
    localparam int LUN_COUNT  = 2;
    localparam int ARRAY_OP_CYCLES = 64;  // length of a modelled array operation
    localparam logic [7:0] DQ_RESET = 8'h00;
    localparam logic [7:0] CMD_PROGRAM_CONFIRM = 8'h10;
    localparam logic [7:0] CMD_ERASE_CONFIRM   = 8'hD0;
    localparam logic [7:0] CMD_READ_CONFIRM    = 8'h30;

    // host control lines as seen after synchronising
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n_clk;   // write strobe, or clock in synchronous mode
        logic re_n_wr_n;  // read strobe, or direction select in synchronous mode
        logic wp_n;
    } host_ctl_type;

    // one byte latched from the bus
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } bus_byte_type;
endpackage : nand_port_pkg

// ### hdl/nand_dual_mode_port.sv
/*
 * pin-level host port of a multi-die flash target: asynchronous strobe
 * mode and synchronous clocked mode, latching command, address and data.
 * assumes host pins are asynchronous to clk_sys and a pull-up on the
 * ready/busy line outside; array behaviour is reduced to a busy timer.
 * a strobe level must stand three clk_sys cycles to be seen; the pads
 * are resolved outside, this block only gives data and output enables.
 */
// Functional notes
// RL1: commands, addresses and data share one eight-bit two-way bus.
// RL2: async mode uses chip enable, cle, ale, write and read strobes.
// RL3: in sync mode write strobe is clock, read strobe is direction.
// RL4: sync data is referenced to dqs, driven by the sending party.
// RL5: with ale high the bus byte goes to the address register.
// RL6: with cle high the bus byte goes to the command register.
// RL7: chip enable low enables the dies of this target.
// RL8: each read strobe pulse presents the next data byte.
// RL9: in sync mode the direction level chooses who drives dq and dqs.
// RL10: write strobe moves command, address and write data inward.
// RL11: in sync mode command and address latch on host clock.
// RL12: write protect low blocks program and erase.
// RL13: ready/busy is open drain, pulled low while any die is busy.
// RL14: each die runs commands and keeps status independently.
// RL15: a target is the set of dies behind one chip enable.
// RL16: dqs stays undriven while the async interface is active.
// RL17: host waits for ready/busy high before a new array operation.
`timescale 1ns/100ps
module nand_dual_mode_port
    import nand_port_pkg::*;
#(
    parameter int OP_CYCLES = ARRAY_OP_CYCLES
) (
    input  wire logic            clk_sys,
    input  wire logic            reset_n,
    input  wire logic            sync_mode,
    input  wire logic            ce_n,
    input  wire logic            cle,
    input  wire logic            ale,
    input  wire logic            we_n_clk,
    input  wire logic            re_n_wr_n,
    input  wire logic            wp_n,
    input  wire logic [DQ_W-1:0] dq_in,
    output logic      [DQ_W-1:0] dq_out,
    output logic                 dq_oe,
    input  wire logic            dqs_in,
    output logic                 dqs_out,
    output logic                 dqs_oe,
    output logic                 rb_n_oe,
    output logic      [7:0]      cmd_r,
    output logic      [7:0]      addr_r,
    output logic      [7:0]      wdata_r,
    output logic                 wdata_valid_r,
    input  wire logic [7:0]      rd_data,
    output logic                 rd_next_r
);
    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    host_ctl_type     ctl_s1_r, ctl_s2_r, ctl_d_r;
    logic [DQ_W-1:0]  dq_s1_r, dq_s2_r;
    logic             mode_s1_r, mode_s2_r, dqs_s1_r, dqs_s2_r, dqs_d_r;
    host_ctl_type     ctl_raw;

    assign ctl_raw = '{ce_n, cle, ale, we_n_clk, re_n_wr_n, wp_n};

    // reset values match idle pins so no false strobe edge follows reset
    // stage two and the delayed copy feed edge detection, never stage one
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctl_s1_r  <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            ctl_s2_r  <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            ctl_d_r   <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            dq_s1_r   <= DQ_RESET;
            dq_s2_r   <= DQ_RESET;
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
            dqs_s1_r  <= 1'b0;
            dqs_s2_r  <= 1'b0;
            dqs_d_r   <= 1'b0;
        end else begin
            ctl_s1_r  <= ctl_raw;
            ctl_s2_r  <= ctl_s1_r;
            ctl_d_r   <= ctl_s2_r;
            dq_s1_r   <= dq_in;
            dq_s2_r   <= dq_s1_r;
            mode_s1_r <= sync_mode;
            mode_s2_r <= mode_s1_r;
            dqs_s1_r  <= dqs_in;
            dqs_s2_r  <= dqs_s1_r;
            dqs_d_r   <= dqs_s2_r;
        end
    end

    // -------------------------------------------------------------
    // strobe decode
    // -------------------------------------------------------------
    // limitation: a level shorter than three clocks may lose its edge
    // dqs edges of either polarity carry a byte, as double data rate asks
    logic sel;         // target selected by chip enable
    logic we_rise;     // write strobe or host clock rose
    logic re_fall;     // read strobe fell
    logic clk_rise;    // host clock rose, synchronous mode
    logic dqs_edge;    // host data strobe changed level
    logic in_strobe;   // a byte on the bus is to be taken
    assign sel      = !ctl_s2_r.ce_n;                                  // see RL7 RL15
    assign we_rise  = ctl_s2_r.we_n_clk && !ctl_d_r.we_n_clk;          // see RL10
    assign re_fall  = !ctl_s2_r.re_n_wr_n && ctl_d_r.re_n_wr_n;        // see RL8
    assign clk_rise = we_rise;                                         // see RL3 RL11
    assign dqs_edge = dqs_s2_r != dqs_d_r;                             // see RL4
    // async bytes on write strobe rise; sync cmd/addr on clock, data on dqs
    assign in_strobe = mode_s2_r ? ((ctl_s2_r.cle || ctl_s2_r.ale) ? clk_rise
                                    : (dqs_edge && ctl_s2_r.re_n_wr_n))
                                 : we_rise;                            // see RL2 RL9

    // -------------------------------------------------------------
    // latch state and per-die busy timers
    // -------------------------------------------------------------
    logic [7:0]  cmd_nxt, addr_nxt, wdata_nxt;
    logic        wdata_valid_nxt, rd_next_nxt;
    logic [31:0] busy_cnt_r [LUN_COUNT];
    logic [31:0] busy_cnt_nxt [LUN_COUNT];
    logic        lun_sel_r, lun_sel_nxt;
    logic        any_busy;

    // program and erase need write protect released; a page read never does
    function automatic logic starts_array_op(input logic [7:0] code,
                                             input logic       wp_released);
        logic is_write_op;
        is_write_op = (code == CMD_PROGRAM_CONFIRM) || (code == CMD_ERASE_CONFIRM);
        return (is_write_op && wp_released) || (code == CMD_READ_CONFIRM);  // see RL12
    endfunction

    // next values of the latches and of the per-die busy timers
    // a confirm in the same cycle as the count wins, so a new operation restarts
    always_comb begin
        cmd_nxt         = cmd_r;
        addr_nxt        = addr_r;
        wdata_nxt       = wdata_r;
        wdata_valid_nxt = 1'b0;
        rd_next_nxt     = 1'b0;
        lun_sel_nxt     = lun_sel_r;
        any_busy        = 1'b0;
        // each die counts its own operation down, apart from the others
        for (int i = 0; i < LUN_COUNT; i++) begin
            busy_cnt_nxt[i] = (busy_cnt_r[i] != 32'h0) ? busy_cnt_r[i] - 32'h1
                                                       : busy_cnt_r[i];   // see RL14
            any_busy = any_busy || (busy_cnt_r[i] != 32'h0);
        end
        if (sel && in_strobe) begin                                    // see RL1
            if (ctl_s2_r.cle) begin
                cmd_nxt = dq_s2_r;                                     // see RL6
                if (starts_array_op(dq_s2_r, ctl_s2_r.wp_n))           // see RL12
                    busy_cnt_nxt[lun_sel_r] = 32'(OP_CYCLES);
            end else if (ctl_s2_r.ale) begin
                addr_nxt    = dq_s2_r;                                 // see RL5
                // two dies: the top address bit picks which timer a confirm starts
                lun_sel_nxt = dq_s2_r[DQ_W-1];
            end else begin
                wdata_nxt       = dq_s2_r;
                wdata_valid_nxt = 1'b1;
            end
        end
        // async read strobe fall, or sync read edge, asks for next byte
        if (sel && !ctl_s2_r.cle && !ctl_s2_r.ale &&
            (mode_s2_r ? (!ctl_s2_r.re_n_wr_n && clk_rise) : re_fall))
            rd_next_nxt = 1'b1;                                        // see RL8
    end

    // register the latch state; reset clears every die's timer
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cmd_r         <= DQ_RESET;
            addr_r        <= DQ_RESET;
            wdata_r       <= DQ_RESET;
            wdata_valid_r <= 1'b0;
            rd_next_r     <= 1'b0;
            lun_sel_r     <= 1'b0;
            for (int i = 0; i < LUN_COUNT; i++) busy_cnt_r[i] <= 32'h0;
        end else begin
            cmd_r         <= cmd_nxt;
            addr_r        <= addr_nxt;
            wdata_r       <= wdata_nxt;
            wdata_valid_r <= wdata_valid_nxt;
            rd_next_r     <= rd_next_nxt;
            lun_sel_r     <= lun_sel_nxt;
            for (int i = 0; i < LUN_COUNT; i++) busy_cnt_r[i] <= busy_cnt_nxt[i];
        end
    end

    // -------------------------------------------------------------
    // pin drivers
    // -------------------------------------------------------------
    logic       dq_oe_nxt, dqs_oe_nxt, dqs_out_nxt, rb_n_oe_nxt;
    logic [7:0] dq_out_nxt;

    // device drives dq and dqs only when selected and the host asks for a read
    // limitation: rd_data is taken every cycle, so the core holds it while driven
    always_comb begin
        // read strobe low (async) and direction low (sync) both hand the bus over
        dq_oe_nxt   = sel && !ctl_s2_r.re_n_wr_n;                      // see RL8 RL9
        dq_out_nxt  = rd_data;
        dqs_oe_nxt  = sel && mode_s2_r && !ctl_s2_r.re_n_wr_n;         // see RL4 RL16
        dqs_out_nxt = dqs_out ^ (dqs_oe_nxt && clk_rise);
        // ready/busy is shared by the target, so any busy die pulls it low
        rb_n_oe_nxt = any_busy;                                        // see RL13
    end

    // pins leave from flip-flops so no decode glitch reaches the pads
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dq_out  <= DQ_RESET;
            dq_oe   <= 1'b0;
            dqs_out <= 1'b0;
            dqs_oe  <= 1'b0;
            rb_n_oe <= 1'b0;
        end else begin
            dq_out  <= dq_out_nxt;
            dq_oe   <= dq_oe_nxt;
            dqs_out <= dqs_out_nxt;
            dqs_oe  <= dqs_oe_nxt;
            rb_n_oe <= rb_n_oe_nxt;
        end
    end
endmodule // nand_dual_mode_port

// ### testbench/nand_port_props.sv
/* checker on the flash pin port outputs.
   assumes host levels are held four clocks and a short busy time. */
`timescale 1ns/100ps
module nand_port_props
    import nand_port_pkg::*;
#(parameter int OP_CYCLES = 8) (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       sync_mode,
    input wire logic       ce_n,
    input wire logic       cle,
    input wire logic       ale,
    input wire logic       re_n_wr_n,
    input wire logic       wp_n,
    input wire logic [7:0] dq_in,
    input wire logic       dq_oe,
    input wire logic       dqs_oe,
    input wire logic       rb_n_oe,
    input wire logic [7:0] cmd_r,
    input wire logic [7:0] addr_r,
    input wire logic       wdata_valid_r,
    input wire logic       rd_next_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // six-cycle windows allow for the input synchronisers
    a_dqs_async_off: assert property (!sync_mode [*6] |-> !dqs_oe)
        else $error("strobe driven in async mode");
    a_ce_quiet: assert property (ce_n [*6] |-> !wdata_valid_r && !rd_next_r && !dq_oe)
        else $error("activity while deselected");
    a_cmd_capture: assert property ($changed(cmd_r) |-> $past(cle, 3) && cmd_r == $past(dq_in, 3))
        else $error("command byte not from bus");
    a_addr_capture: assert property ($changed(addr_r) |-> $past(ale, 3) && addr_r == $past(dq_in, 3))
        else $error("address byte not from bus");
    // busy length is fixed to the short simulation value
    a_busy_hold: assert property ($rose(rb_n_oe) |-> rb_n_oe [*8])
        else $error("busy dropped early");
    a_busy_cause: assert property ($rose(rb_n_oe) |-> $past(wp_n, 4) || cmd_r == CMD_READ_CONFIRM)
        else $error("busy while write protected");
    a_wdata_pulse: assert property (wdata_valid_r |-> !$past(cle, 3) ##1 !wdata_valid_r)
        else $error("bad write data pulse");
    a_read_pulse: assert property (rd_next_r |=> !rd_next_r)
        else $error("read advance too long");
    a_dir_host: assert property (re_n_wr_n [*6] |-> !dq_oe && !dqs_oe)
        else $error("device drives against host");
    c_busy: cover property ($rose(rb_n_oe));
    c_read: cover property (rd_next_r);
    c_sync_out: cover property (dqs_oe && dq_oe);
    c_sync_write: cover property (sync_mode && wdata_valid_r);
endmodule // nand_port_props
bind nand_dual_mode_port nand_port_props #(.OP_CYCLES(OP_CYCLES)) nand_port_props_i (.*);

// ### testbench/nand_host_model.sv
/* host controller pin model: strobes, latch enables and bus byte.
   assumes the bench resolves the bus and the pulled-up busy line. */
`timescale 1ns/100ps
module nand_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] dq_in,
    input  wire logic       rb_n,
    output logic            ce_n      = 1'b1,
    output logic            cle       = 1'b0,
    output logic            ale       = 1'b0,
    output logic            we_n_clk  = 1'b1,
    output logic            re_n_wr_n = 1'b1,
    output logic      [7:0] host_dq   = 8'h00
);
    // each level held four clocks, giving the 64 ns link period
    task automatic hold4;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    // one byte moved in per rising strobe or clock
    task automatic put(input logic c, input logic a, input logic [7:0] v);
        {cle, ale, host_dq, we_n_clk} = {c, a, v, 1'b0};
        hold4();
        we_n_clk = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        {cle, ale, host_dq} = {2'b00, ~v};  // released bus must not keep the old byte
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    // a read strobe pulse fetches the next byte
    task automatic get(output logic [7:0] v);
        re_n_wr_n = 1'b0;
        hold4();
        v = dq_in;
        re_n_wr_n = 1'b1;
        hold4();
    endtask
    // no new array operation while the busy line is low
    task automatic wait_ready;
        for (int t = 0; t < 99 && rb_n !== 1'b1; t++) @(posedge clk_sys);
        #1;
    endtask
endmodule // nand_host_model

// ### testbench/nand_dual_mode_signal_interface_bench.sv
/* self-checking bench for the dual-mode flash pin port.
   assumes the host pin model and the bound checker. */
`timescale 1ns/100ps
module nand_dual_mode_signal_interface_bench;
    import nand_port_pkg::*;
    logic       clk_sys = 1'b0, reset_n = 1'b0, sync_mode = 1'b0, wp_n = 1'b1, dqs_in = 1'b0;
    logic       ce_n, cle, ale, we_n_clk, re_n_wr_n, dq_oe, dqs_out, dqs_oe, rb_n_oe;
    logic       wdata_valid_r, rd_next_r;
    logic [7:0] rd_data = 8'h00, host_dq, dq_out, cmd_r, addr_r, wdata_r, b, d;
    logic [7:0] cf [3] = '{CMD_PROGRAM_CONFIRM, CMD_ERASE_CONFIRM, CMD_READ_CONFIRM};
    wire  [7:0] dq_in = dq_oe ? dq_out : host_dq;
    wire        rb_n  = ~rb_n_oe;  // open drain with pull-up
    int         n_errors = 0, tests_run = 0, n_wv = 0, n_rd = 0;
    nand_dual_mode_port #(.OP_CYCLES(8)) nand_dual_mode_port_i (
        .clk_sys       (clk_sys),
        .reset_n       (reset_n),
        .sync_mode     (sync_mode),
        .ce_n          (ce_n),
        .cle           (cle),
        .ale           (ale),
        .we_n_clk      (we_n_clk),
        .re_n_wr_n     (re_n_wr_n),
        .wp_n          (wp_n),
        .dq_in         (dq_in),
        .dq_out        (dq_out),
        .dq_oe         (dq_oe),
        .dqs_in        (dqs_in),
        .dqs_out       (dqs_out),
        .dqs_oe        (dqs_oe),
        .rb_n_oe       (rb_n_oe),
        .cmd_r         (cmd_r),
        .addr_r        (addr_r),
        .wdata_r       (wdata_r),
        .wdata_valid_r (wdata_valid_r),
        .rd_data       (rd_data),
        .rd_next_r     (rd_next_r)
    );
    nand_host_model nand_host_model_i (
        .clk_sys   (clk_sys),
        .dq_in     (dq_in),
        .rb_n      (rb_n),
        .ce_n      (ce_n),
        .cle       (cle),
        .ale       (ale),
        .we_n_clk  (we_n_clk),
        .re_n_wr_n (re_n_wr_n),
        .host_dq   (host_dq)
    );
    always #4 clk_sys = ~clk_sys;
    // pulse counters
    always @(posedge clk_sys) begin
        n_wv <= n_wv + int'(wdata_valid_r === 1'b1);
        n_rd <= n_rd + int'(rd_next_r === 1'b1);
    end
    function automatic logic exp_busy(input logic [7:0] c, input logic w);
        return c == CMD_READ_CONFIRM || (w && (c == CMD_PROGRAM_CONFIRM || c == CMD_ERASE_CONFIRM));
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t: byte %h want %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #50us;
        n_errors++;
        end_sim();
    end
    initial begin
        void'($urandom(57));
        repeat (20) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        chk1(rb_n_oe, 1'b0);
        nand_host_model_i.ce_n = 1'b0;
        for (int i = 0; i < 8; i++) begin
            b = 8'($urandom) | 8'h01;  // never a confirm code
            nand_host_model_i.put(1'b1, 1'b0, b);
            chk8(cmd_r, b);
            nand_host_model_i.put(1'b0, 1'b1, ~b);
            chk8(addr_r, ~b);
            nand_host_model_i.put(1'b0, 1'b0, b ^ 8'h5A);
            chk8(wdata_r, b ^ 8'h5A);
        end
        chk8(8'(n_wv), 8'h08);
        nand_host_model_i.ce_n = 1'b1;
        nand_host_model_i.put(1'b1, 1'b0, 8'h3C);
        chk8(cmd_r, b);
        nand_host_model_i.ce_n = 1'b0;
        foreach (cf[k]) for (int w = 0; w < 2; w++) begin
            wp_n = w[0];
            nand_host_model_i.put(1'b0, 1'b1, {k[0], 7'h00});  // die select
            nand_host_model_i.put(1'b1, 1'b0, cf[k]);
            repeat (2) @(posedge clk_sys);
            #1;
            chk1(rb_n_oe, exp_busy(cf[k], w[0]));
            nand_host_model_i.wait_ready();
            chk1(rb_n_oe, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            rd_data = 8'($urandom);
            nand_host_model_i.get(d);
            chk8(d, rd_data);
        end
        chk8(8'(n_rd), 8'h04);
        sync_mode = 1'b1;
        nand_host_model_i.hold4();
        nand_host_model_i.put(1'b1, 1'b0, 8'h71);
        chk8(cmd_r, 8'h71);
        nand_host_model_i.re_n_wr_n = 1'b0;
        nand_host_model_i.put(1'b0, 1'b0, 8'hFF);
        chk1(dqs_oe && dq_oe, 1'b1);
        chk1(dqs_out, 1'b1);
        chk8(8'(n_rd), 8'h05);
        nand_host_model_i.re_n_wr_n = 1'b1;
        repeat (2) nand_host_model_i.hold4();
        chk1(dqs_oe || dq_oe, 1'b0);
        for (int j = 0; j < 2; j++) begin
            d = 8'($urandom);
            nand_host_model_i.host_dq = d;
            nand_host_model_i.hold4();
            dqs_in = ~dqs_in;
            nand_host_model_i.hold4();
            chk8(wdata_r, d);
        end
        chk8(8'(n_wv), 8'h0A);
        end_sim();
    end
endmodule // nand_dual_mode_signal_interface_bench
